/* File: gpalt_cfg.svh */
// constants for the pin port with alternate functions
`ifndef GPALT_CFG_SVH
`define GPALT_CFG_SVH

//------------------------------------------------------------------------------
// register indices and byte addresses
//------------------------------------------------------------------------------
`define GPALT_IDX_FSEL      8'h4f
`define GPALT_IDX_ODATA     8'h50
`define GPALT_IDX_DIR       8'h51
`define GPALT_IDX_IDATA     8'h52
`define GPALT_IDX_ANT       8'h5f
`define GPALT_ADDR_FSEL     {2'h0, `GPALT_IDX_FSEL, 2'h0}
`define GPALT_ADDR_ODATA    {2'h0, `GPALT_IDX_ODATA, 2'h0}
`define GPALT_ADDR_DIR      {2'h0, `GPALT_IDX_DIR, 2'h0}
`define GPALT_ADDR_IDATA    {2'h0, `GPALT_IDX_IDATA, 2'h0}
`define GPALT_ADDR_ANT      {2'h0, `GPALT_IDX_ANT, 2'h0}

//------------------------------------------------------------------------------
// field positions, masks and reset values
//------------------------------------------------------------------------------
`define GPALT_FSEL_PIN7     7
`define GPALT_FSEL_PIN65    6
`define GPALT_FSEL_MASK     8'hc0
`define GPALT_PIN_MASK      8'hfd
`define GPALT_ANT_MODE      0
`define GPALT_ANT_MASK      8'h01
`define GPALT_FSEL_RST      8'h00
`define GPALT_ODATA_RST     8'h00
`define GPALT_DIR_RST       8'hff
`define GPALT_ANT_RST       8'h00
`define GPALT_RESP_OKAY     2'h0
`define GPALT_RESP_SLVERR   2'h2

`endif

/* File: gpalt_pkg.sv */
// types for the pin port with alternate functions
package gpalt_pkg;

    typedef logic [7:0] gpalt_byte_t;

    typedef struct packed {
        gpalt_byte_t fsel;
        gpalt_byte_t odata;
        gpalt_byte_t dir;
        gpalt_byte_t ant;
        gpalt_byte_t sync1;
        gpalt_byte_t sync2;
        gpalt_byte_t pad_out;
        gpalt_byte_t pad_oe;
        logic        ant_in;
        logic        aw_got;
        logic [11:0] awaddr;
        logic        w_got;
        gpalt_byte_t wdata;
        logic        wstrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        gpalt_byte_t rdata;
        logic [1:0]  rresp;
    } gpalt_state_s;

endpackage : gpalt_pkg

/* File: gpalt_port.sv */
// pin port with alternate functions behind an axi4-lite slave
`timescale 1ns/1ps
`include "gpalt_cfg.svh"

module gpalt_port
    import gpalt_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    // axi4-lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // core signals routed to pins
    input  wire logic        host_interrupt_request,
    input  wire logic        sync_output,
    input  wire logic        antenna_direction,
    // core signals taken from pins and from the antenna register
    output logic             antenna_control_input,
    output logic             antenna_two_pin_mode,
    // pins
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe
);

    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    gpalt_state_s state_q;
    gpalt_state_s state_d;

    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        wr_fire;
    logic [11:0] wr_addr;
    gpalt_byte_t wr_data;
    logic        wr_lane0;
    logic        wr_hit;
    gpalt_byte_t rd_data;
    logic        rd_hit;
    logic        two_pin;
    logic        pin7_alt;
    logic        pin65_alt;
    gpalt_byte_t drv_val;
    gpalt_byte_t drv_en;
    gpalt_byte_t live;

    //--------------------------------------------------------------------------
    // handshakes
    //--------------------------------------------------------------------------
    // no new write is taken while a response waits, so one write at a time
    assign s_axi_awready = !state_q.aw_got && !state_q.bvalid;
    assign s_axi_wready  = !state_q.w_got && !state_q.bvalid;
    assign s_axi_arready = !state_q.rvalid;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign s_axi_bvalid          = state_q.bvalid;
    assign s_axi_bresp           = state_q.bresp;
    assign s_axi_rvalid          = state_q.rvalid;
    assign s_axi_rdata           = {24'h0, state_q.rdata};
    assign s_axi_rresp           = state_q.rresp;
    assign antenna_control_input = state_q.ant_in;
    assign antenna_two_pin_mode  = state_q.ant[`GPALT_ANT_MODE];
    assign pin_out               = state_q.pad_out;
    assign pin_oe                = state_q.pad_oe;

    //--------------------------------------------------------------------------
    // pin routing
    //--------------------------------------------------------------------------
    assign two_pin   = state_q.ant[`GPALT_ANT_MODE];
    assign pin7_alt  = state_q.fsel[`GPALT_FSEL_PIN7];
    assign pin65_alt = state_q.fsel[`GPALT_FSEL_PIN65];
    // only the second stage of the pin synchroniser is looked at
    assign live      = state_q.sync2 & `GPALT_PIN_MASK;

    always_comb begin
        // plain pins: drive data only while configured as outputs
        drv_val = state_q.odata;
        drv_en  = ~state_q.dir;
        drv_en  = drv_en & `GPALT_PIN_MASK;
        drv_val = drv_val & drv_en;
        if (pin7_alt) begin
            drv_val[7] = host_interrupt_request;
            drv_en[7]  = 1'b1;
        end
        if (pin65_alt) begin
            drv_val[5] = sync_output;
            drv_en[5]  = 1'b1;
            drv_val[6] = 1'b0;
            drv_en[6]  = 1'b0;
        end
        // pin 1 has no plain role, it always carries the direction
        drv_val[1] = antenna_direction;
        drv_en[1]  = 1'b1;
        if (two_pin) begin
            drv_val[0] = 1'b0;
            drv_en[0]  = 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // write path
    //--------------------------------------------------------------------------
    // address and data may come in either order; whichever is held is used
    always_comb begin
        wr_addr  = state_q.aw_got ? state_q.awaddr : s_axi_awaddr;
        wr_data  = state_q.w_got ? state_q.wdata : s_axi_wdata[7:0];
        wr_lane0 = state_q.w_got ? state_q.wstrb0 : s_axi_wstrb[0];
        wr_fire  = (state_q.aw_got || aw_take) && (state_q.w_got || w_take);
        unique case ({wr_addr[11:2], 2'h0})
            `GPALT_ADDR_FSEL,
            `GPALT_ADDR_ODATA,
            `GPALT_ADDR_DIR,
            `GPALT_ADDR_IDATA,
            `GPALT_ADDR_ANT: wr_hit = 1'b1;
            default:         wr_hit = 1'b0;
        endcase
    end

    //--------------------------------------------------------------------------
    // read decode
    //--------------------------------------------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[11:2], 2'h0})
            `GPALT_ADDR_FSEL:  rd_data = state_q.fsel & `GPALT_FSEL_MASK;
            `GPALT_ADDR_ODATA: rd_data = state_q.odata & `GPALT_PIN_MASK;
            `GPALT_ADDR_DIR:   rd_data = state_q.dir;
            `GPALT_ADDR_IDATA: rd_data = live;
            `GPALT_ADDR_ANT:   rd_data = state_q.ant & `GPALT_ANT_MASK;
            default: begin
                rd_data = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
    end

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        // two stage synchroniser on every pin
        state_d.sync1  = pin_in;
        state_d.sync2  = state_q.sync1;
        state_d.ant_in = two_pin ? state_q.sync2[0] : 1'b0;

        // pin drive comes from flops
        state_d.pad_out = drv_val;
        state_d.pad_oe  = drv_en;

        // write channel capture
        if (aw_take && !wr_fire) begin
            state_d.aw_got = 1'b1;
            state_d.awaddr = s_axi_awaddr;
        end
        if (w_take && !wr_fire) begin
            state_d.w_got  = 1'b1;
            state_d.wdata  = s_axi_wdata[7:0];
            state_d.wstrb0 = s_axi_wstrb[0];
        end

        if (wr_fire) begin
            state_d.aw_got = 1'b0;
            state_d.w_got  = 1'b0;
            state_d.bvalid = 1'b1;
            state_d.bresp  = wr_hit ? `GPALT_RESP_OKAY : `GPALT_RESP_SLVERR;
            if (wr_lane0) begin
                unique case ({wr_addr[11:2], 2'h0})
                    `GPALT_ADDR_FSEL: begin
                        state_d.fsel = wr_data & `GPALT_FSEL_MASK;
                    end
                    `GPALT_ADDR_ODATA: begin
                        state_d.odata = wr_data & `GPALT_PIN_MASK;
                    end
                    `GPALT_ADDR_DIR: begin
                        state_d.dir = wr_data;
                    end
                    `GPALT_ADDR_ANT: begin
                        state_d.ant = wr_data & `GPALT_ANT_MASK;
                    end
                    default: begin
                        state_d.fsel = state_q.fsel;
                    end
                endcase
            end
        end else if (state_q.bvalid && s_axi_bready) begin
            state_d.bvalid = 1'b0;
        end

        // read channel
        if (ar_take) begin
            state_d.rvalid = 1'b1;
            state_d.rdata  = rd_data;
            state_d.rresp  = rd_hit ? `GPALT_RESP_OKAY : `GPALT_RESP_SLVERR;
        end else if (state_q.rvalid && s_axi_rready) begin
            state_d.rvalid = 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // registers
    //--------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q       <= '0;
            state_q.fsel  <= `GPALT_FSEL_RST;
            state_q.odata <= `GPALT_ODATA_RST;
            state_q.dir   <= `GPALT_DIR_RST;
            state_q.ant   <= `GPALT_ANT_RST;
        end else begin
            state_q <= state_d;
        end
    end

endmodule : gpalt_port

/* File: gpalt_assertions.sv */
// concurrent checks on the ports of the pin port
`timescale 1ns/1ps
module gpalt_assertions (
    // clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // antenna and pins
    input wire logic        antenna_direction,
    input wire logic        antenna_control_input,
    input wire logic        antenna_two_pin_mode,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    //--------------------------------------------------------------------------
    // handshake steps
    //--------------------------------------------------------------------------
    sequence aw_taken; s_axi_awvalid && s_axi_awready; endsequence
    sequence w_taken; s_axi_wvalid && s_axi_wready; endsequence
    sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence r_given; s_axi_rvalid && s_axi_rdata[31:8] == 24'h0; endsequence
    b_answer_a: assert property (aw_taken ##0 w_taken |=> s_axi_bvalid)
        else $error("write response late");
    r_answer_a: assert property (ar_taken |=> r_given)
        else $error("read answer late or upper bits set");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    dir_pin_a: assert property (rstn && $past(rstn) |-> pin_oe[1] && pin_out[1] == $past(antenna_direction))
        else $error("pin 1 not carrying antenna direction");
    undriven_zero_a: assert property ((pin_out & ~pin_oe) == 8'h00)
        else $error("value on undriven pin");
    two_pin_release_a: assert property (antenna_two_pin_mode |=> !pin_oe[0])
        else $error("pin 0 driven in two-pin mode");
    acin_idle_a: assert property (!antenna_two_pin_mode |=> !antenna_control_input)
        else $error("antenna control input active in single-pin mode");
endmodule : gpalt_assertions

bind gpalt_port gpalt_assertions u_chk (
    .clock(clock), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .antenna_direction(antenna_direction),
    .antenna_control_input(antenna_control_input),
    .antenna_two_pin_mode(antenna_two_pin_mode), .pin_out(pin_out), .pin_oe(pin_oe));

/* File: gpalt_board.sv */
// board model on the far side of the pins
`timescale 1ns/1ps
module gpalt_board (
    // pads from the port
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // level the board puts on released pins
    input  wire logic [7:0] ext,
    output logic      [7:0] pin_in
);
    // driven pins read back the port, released ones the board's own level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : gpalt_board

/* File: gpalt_port_bench.sv */
// self-checking bench for the pin port
`timescale 1ns/1ps
`include "gpalt_cfg.svh"
module gpalt_port_bench import gpalt_pkg::*; ;
    logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready, irq, sync, adir;
    logic        awready, wready, bvalid, arready, rvalid, acin, two_pin;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, t;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, k;
    gpalt_byte_t pin_in, pin_out, pin_oe, ext;
    gpalt_byte_t mdl [4];
    logic [11:0] adr [4] = '{`GPALT_ADDR_FSEL, `GPALT_ADDR_ODATA, `GPALT_ADDR_DIR, `GPALT_ADDR_ANT};
    gpalt_byte_t msk [4] = '{8'hc0, 8'hfd, 8'hff, 8'h01};
    logic [31:0] seed = 32'h0000ac8e;
    int          fail_count, n_checks;
    gpalt_port u_dut (
        .clock(clock), .rstn(rstn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .host_interrupt_request(irq),
        .sync_output(sync), .antenna_direction(adir), .antenna_control_input(acin),
        .antenna_two_pin_mode(two_pin), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    gpalt_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    //--------------------------------------------------------------------------
    // expected pin drive from the register model
    //--------------------------------------------------------------------------
    function automatic gpalt_byte_t e_oe();
        e_oe = (~mdl[2] & 8'hfd) | 8'h02;
        if (mdl[0][7]) e_oe[7] = 1'b1;
        if (mdl[0][6]) e_oe[6:5] = 2'b01;
        if (mdl[3][0]) e_oe[0] = 1'b0;
    endfunction : e_oe
    function automatic gpalt_byte_t e_out();
        e_out = mdl[1] & e_oe();
        e_out[1] = adir;
        if (mdl[0][7]) e_out[7] = irq;
        if (mdl[0][6]) e_out[5] = sync;
    endfunction : e_out
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input gpalt_byte_t d, input logic [3:0] s,
                      input logic [1:0] r);
        logic ta, tw, tb;
        logic [1:0] got_r;
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            got_r = bresp;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            // ready one cycle after the response rises exercises the response hold
            bready <= !tb && !awvalid && !wvalid;
        end while (!tb);
        chk("bresp", r, got_r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input gpalt_byte_t e, input logic [1:0] r);
        logic ta, tb;
        logic [31:0] got;
        logic [1:0] got_r;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clock);
            ta = arvalid && arready;
            tb = rvalid && rready;
            got = rdata;
            got_r = rresp;
            @(posedge clock);
            if (ta) arvalid <= 1'b0;
            rready <= !tb && !arvalid;
        end while (!tb);
        chk("rdata", {24'h0, e}, got);
        chk("rresp", r, got_r);
    endtask : rd
    task automatic settle();
        gpalt_byte_t w;
        repeat (4) @(posedge clock);
        @(negedge clock);
        w = (e_oe() & e_out()) | (~e_oe() & ext);
        chk("pin_oe", e_oe(), pin_oe);
        chk("pin_out", e_out(), pin_out);
        chk("two_pin", mdl[3][0], two_pin);
        chk("acin", mdl[3][0] & ext[0], acin);
        @(posedge clock);
        rd(`GPALT_ADDR_IDATA, w & 8'hfd, `GPALT_RESP_OKAY);
        for (int i = 0; i < 4; i++) rd(adr[i], mdl[i], `GPALT_RESP_OKAY);
    endtask : settle
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        end_of_test();
    end
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, irq, sync, adir} = 9'h0;
        {awaddr, araddr, wdata, wstrb, ext} = '0;
        mdl = '{8'h00, 8'h00, 8'hff, 8'h00};
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        settle();
        rd(12'h000, 8'h00, `GPALT_RESP_SLVERR);
        wr(12'h000, 8'hff, 4'hf, `GPALT_RESP_SLVERR);
        wr(`GPALT_ADDR_IDATA, 8'hff, 4'hf, `GPALT_RESP_OKAY);
        wr(adr[1], 8'hff, 4'h0, `GPALT_RESP_OKAY);
        settle();
        $display("test reset_map done");
        mdl[1] = 8'hfd;
        wr(adr[1], 8'hff, 4'h1, `GPALT_RESP_OKAY);
        mdl[2] = 8'h00;
        wr(adr[2], 8'h00, 4'h1, `GPALT_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            mdl[0] = {i[1:0], 6'h0};
            wr(adr[0], 8'hff & {i[1:0], 6'h3f}, 4'h1, `GPALT_RESP_OKAY);
            settle();
        end
        $display("test role_select done");
        for (int i = 0; i < 40; i++) begin
            t = xs();
            k = t[17:16];
            irq <= t[0];
            sync <= t[1];
            adir <= t[2];
            ext <= t[15:8];
            mdl[k] = t[31:24] & msk[k];
            wr(adr[k], t[31:24], 4'h1, `GPALT_RESP_OKAY);
            settle();
        end
        $display("test random_drive done");
        // a second reset in mid-run must bring every register back to its default
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        mdl = '{8'h00, 8'h00, 8'hff, 8'h00};
        @(posedge clock);
        settle();
        $display("test mid_reset done");
        end_of_test();
    end
endmodule : gpalt_port_bench
